// *** design/rrs_exec.sv ***
`timescale 1ns/1ps
// Summary of operation
// - A literal return loads its 8-bit immediate into W and changes no flag.
// - A literal return pops the stack into the program counter and takes 2 cycles.
// - A plain return pops the stack into the counter, changes no flag and takes two cycles.
// - Rotate left shifts a file register through carry in 1 cycle, changing only carry.
// - Rotate left takes address 0 to 127; dest 0 writes W and dest 1 writes the file back.
// - The halt instruction clears the power-down flag to 0 and sets the time-out flag to 1.
// - The halt instruction clears the watchdog counter to 00h and clears its prescaler.
// - After halt the core enters its low-power state with the oscillator stopped.
module rrs_exec
	import rrs_pkg::*;
#(
	parameter int PC_W = RRS_PC_W_DEF
)
(
	// Clock and reset.
	input wire logic clk,
	input wire logic rstn,
	// Instruction issue.
	input wire logic insn_valid,
	input wire rrs_insn_s insn,
	output logic insn_ready,
	// Return-address stack and program counter.
	input wire logic [PC_W-1:0] stack_top_entry,
	output logic stack_pop,
	output logic pc_load,
	output logic [PC_W-1:0] pc_value,
	// Working register.
	output logic w_write,
	output logic [RRS_DATA_W-1:0] w_data,
	// Register file.
	output logic file_write,
	output logic [RRS_FADDR_W-1:0] file_addr,
	output logic [RRS_DATA_W-1:0] file_data,
	// Status flags.
	output logic carry_write,
	output logic carry_value,
	output logic timeout_flag_n,
	output logic powerdown_flag_n,
	// Watchdog and oscillator.
	output logic watchdog_clear,
	output logic prescaler_clear,
	output logic [RRS_DATA_W-1:0] watchdog_counter,
	output logic osc_stop,
	output logic halted,
	input wire logic wake
);

	////////////////////////////////////////////////////////////////////////////////
	logic rst_meta_q;
	logic rst_n_q;
	logic wake_meta_q;
	logic wake_sync_q;
	rrs_state_e state_q;
	rrs_state_e state_d;
	logic accept;
	logic [RRS_DATA_W-1:0] rot_result;
	logic rot_carry;
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			rst_meta_q <= 1'b0;
			rst_n_q <= 1'b0;
		end
		else
		begin
			rst_meta_q <= 1'b1;
			rst_n_q <= rst_meta_q;
		end
	end
	// The wake pin is asynchronous, so it is only read after two flops.
	always_ff @(posedge clk or negedge rst_n_q)
	begin
		if (!rst_n_q)
		begin
			wake_meta_q <= 1'b0;
			wake_sync_q <= 1'b0;
		end
		else
		begin
			wake_meta_q <= wake;
			wake_sync_q <= wake_meta_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	assign accept = insn_valid && insn_ready;
	always_comb
	begin
		state_d = state_q;
		case (state_q)
			RRS_ST_RUN:
			begin
				if (accept && (insn.op == RRS_OP_RET_LIT || insn.op == RRS_OP_RETURN))
				begin
					state_d = RRS_ST_FLUSH;
				end
				else if (accept && insn.op == RRS_OP_HALT)
				begin
					state_d = RRS_ST_HALT;
				end
			end
			RRS_ST_FLUSH:
			begin
				state_d = RRS_ST_RUN;
			end
			RRS_ST_HALT:
			begin
				if (wake_sync_q)
				begin
					state_d = RRS_ST_RUN;
				end
			end
			default:
			begin
				state_d = RRS_ST_RUN;
			end
		endcase
	end
	always_ff @(posedge clk or negedge rst_n_q)
	begin
		if (!rst_n_q)
		begin
			state_q <= RRS_ST_RUN;
			insn_ready <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			insn_ready <= (state_d == RRS_ST_RUN);
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	// pop into counter.
	always_ff @(posedge clk or negedge rst_n_q)
	begin
		if (!rst_n_q)
		begin
			stack_pop <= 1'b0;
			pc_load <= 1'b0;
			pc_value <= '0;
		end
		else
		begin
			stack_pop <= accept && (insn.op == RRS_OP_RET_LIT || insn.op == RRS_OP_RETURN);
			pc_load <= accept && (insn.op == RRS_OP_RET_LIT || insn.op == RRS_OP_RETURN);
			if (accept && (insn.op == RRS_OP_RET_LIT || insn.op == RRS_OP_RETURN))
			begin
				pc_value <= stack_top_entry;
			end
		end
	end
	rrs_rotate u_rotate
	(
		.value(insn.file_data),
		.carry_in(insn.carry),
		.result(rot_result),
		.carry_out(rot_carry)
	);
	always_ff @(posedge clk or negedge rst_n_q)
	begin
		if (!rst_n_q)
		begin
			w_write <= 1'b0;
			w_data <= '0;
		end
		else
		begin
			w_write <= 1'b0;
			if (accept && insn.op == RRS_OP_RET_LIT)
			begin
				w_write <= 1'b1;
				w_data <= insn.literal;
			end
			else if (accept && insn.op == RRS_OP_ROT_LEFT && !insn.dest)
			begin
				w_write <= 1'b1;
				w_data <= rot_result;
			end
		end
	end
	always_ff @(posedge clk or negedge rst_n_q)
	begin
		if (!rst_n_q)
		begin
			file_write <= 1'b0;
			file_addr <= '0;
			file_data <= '0;
		end
		else
		begin
			file_write <= accept && insn.op == RRS_OP_ROT_LEFT && insn.dest;
			if (accept && insn.op == RRS_OP_ROT_LEFT)
			begin
				file_addr <= insn.file_addr;
				file_data <= rot_result;
			end
		end
	end
	always_ff @(posedge clk or negedge rst_n_q)
	begin
		if (!rst_n_q)
		begin
			carry_write <= 1'b0;
			carry_value <= 1'b0;
		end
		else
		begin
			carry_write <= accept && insn.op == RRS_OP_ROT_LEFT;
			if (accept && insn.op == RRS_OP_ROT_LEFT)
			begin
				carry_value <= rot_carry;
			end
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	// halt flag update.
	always_ff @(posedge clk or negedge rst_n_q)
	begin
		if (!rst_n_q)
		begin
			timeout_flag_n <= RRS_TO_N_RST;
			powerdown_flag_n <= RRS_PD_N_RST;
		end
		else if (accept && insn.op == RRS_OP_HALT)
		begin
			timeout_flag_n <= RRS_TO_N_HALT;
			powerdown_flag_n <= RRS_PD_N_HALT;
		end
	end
	always_ff @(posedge clk or negedge rst_n_q)
	begin
		if (!rst_n_q)
		begin
			watchdog_clear <= 1'b0;
			prescaler_clear <= 1'b0;
			watchdog_counter <= RRS_WDT_CLEAR;
		end
		else
		begin
			watchdog_clear <= accept && insn.op == RRS_OP_HALT;
			prescaler_clear <= accept && insn.op == RRS_OP_HALT;
			watchdog_counter <= RRS_WDT_CLEAR;
		end
	end
	always_ff @(posedge clk or negedge rst_n_q)
	begin
		if (!rst_n_q)
		begin
			osc_stop <= 1'b0;
			halted <= 1'b0;
		end
		else
		begin
			osc_stop <= (state_d == RRS_ST_HALT);
			halted <= (state_d == RRS_ST_HALT);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n_q);
	a_retlit_w_load: assert property (accept && insn.op == RRS_OP_RET_LIT |=>
		w_write && w_data == $past(insn.literal) && !carry_write) else $error("bad W load");
	a_ret_pop_pc: assert property (accept &&
		(insn.op == RRS_OP_RET_LIT || insn.op == RRS_OP_RETURN) |=>
		stack_pop && pc_load && pc_value == $past(stack_top_entry)) else $error("bad pop");
	a_return_two_cyc: assert property (accept && insn.op == RRS_OP_RETURN |=>
		!insn_ready && !w_write && !carry_write ##1 insn_ready) else $error("bad return");
	a_rot_one_cyc: assert property (accept && insn.op == RRS_OP_ROT_LEFT |=>
		carry_write && insn_ready && !stack_pop) else $error("rotate not one cycle");
	a_rot_dest_sel: assert property (accept && insn.op == RRS_OP_ROT_LEFT |=>
		(file_write == $past(insn.dest)) && (w_write == !$past(insn.dest)) &&
		file_addr == $past(insn.file_addr)) else $error("rotate destination wrong");
	a_halt_flags_set: assert property (accept && insn.op == RRS_OP_HALT |=>
		!powerdown_flag_n && timeout_flag_n) else $error("halt flags wrong");
	a_halt_wdt_clear: assert property (accept && insn.op == RRS_OP_HALT |=>
		watchdog_clear && prescaler_clear && watchdog_counter == 8'h00)
		else $error("watchdog not cleared");
	a_halt_osc_stop: assert property (accept && insn.op == RRS_OP_HALT |=>
		osc_stop && halted && !insn_ready) else $error("oscillator not stopped");
	a_rot_bits: assert property (accept && insn.op == RRS_OP_ROT_LEFT |=>
		(w_write ? w_data : file_data) == {$past(insn.file_data[6:0]), $past(insn.carry)} &&
		carry_value == $past(insn.file_data[7])) else $error("rotate bits wrong");
	c_ret_lit: cover property (accept && insn.op == RRS_OP_RET_LIT ##2 insn_ready);
	c_rot_file: cover property (accept && insn.op == RRS_OP_ROT_LEFT && insn.dest);
	c_halt_wake: cover property (halted ##[1:50] !halted);

endmodule : rrs_exec

// *** design/rrs_pkg.sv ***
package rrs_pkg;

	localparam int RRS_DATA_W = 8;
	localparam int RRS_FADDR_W = 7;
	localparam int RRS_PC_W_DEF = 13;

	// Bit positions used by the rotate through carry.
	localparam int RRS_ROT_MSB = 7;
	localparam int RRS_ROT_LSB = 0;

	// Values after reset and values loaded by the halt instruction.
	localparam logic RRS_TO_N_RST = 1'b1;
	localparam logic RRS_PD_N_RST = 1'b1;
	localparam logic RRS_TO_N_HALT = 1'b1;
	localparam logic RRS_PD_N_HALT = 1'b0;
	localparam logic [RRS_DATA_W-1:0] RRS_WDT_CLEAR = 8'h00;

	// Instruction cycle counts.
	localparam int RRS_RET_CYCLES = 2;
	localparam int RRS_ROT_CYCLES = 1;

	typedef enum logic [2:0]
	{
		RRS_OP_NONE = 3'b000,
		RRS_OP_RET_LIT = 3'b001,
		RRS_OP_RETURN = 3'b010,
		RRS_OP_ROT_LEFT = 3'b011,
		RRS_OP_HALT = 3'b100
	} rrs_op_e;

	typedef enum logic [1:0]
	{
		RRS_ST_RUN = 2'b00,
		RRS_ST_FLUSH = 2'b01,
		RRS_ST_HALT = 2'b10
	} rrs_state_e;

	typedef struct packed
	{
		rrs_op_e op;
		logic [RRS_DATA_W-1:0] literal;
		logic [RRS_FADDR_W-1:0] file_addr;
		logic dest;
		logic [RRS_DATA_W-1:0] file_data;
		logic carry;
	} rrs_insn_s;

endpackage : rrs_pkg

// *** design/rrs_rotate.sv ***
`timescale 1ns/1ps
module rrs_rotate
	import rrs_pkg::*;
(
	// Operand and carry in.
	input wire logic [RRS_DATA_W-1:0] value,
	input wire logic carry_in,
	// Result and carry out.
	output logic [RRS_DATA_W-1:0] result,
	output logic carry_out
);

	assign result = {value[RRS_ROT_MSB-1:RRS_ROT_LSB], carry_in};
	assign carry_out = value[RRS_ROT_MSB];

endmodule : rrs_rotate

// *** verification/rrs_exec_test.sv ***
`timescale 1ns/1ps
module rrs_exec_test
	import rrs_pkg::*;
;
	typedef struct packed
	{
		rrs_insn_s insn;
		logic [4:0] pulses;
		logic cv;
		logic [7:0] res;
		logic rdy;
	} rrs_row_s;

	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic insn_valid = 1'b0;
	rrs_insn_s insn = '0;
	logic insn_ready;
	logic [12:0] stack_top_entry = 13'h0000;
	logic stack_pop, pc_load, w_write, file_write, carry_write, carry_value;
	logic [12:0] pc_value;
	logic [7:0] w_data, file_data, watchdog_counter;
	logic [6:0] file_addr;
	logic timeout_flag_n, powerdown_flag_n, watchdog_clear, prescaler_clear;
	logic osc_stop, halted;
	logic wake = 1'b0;
	int err_total = 0;
	int checked = 0;
	rrs_row_s rows [9];
	logic seen;

	always #4 clk = ~clk;

	rrs_exec #(.PC_W(13)) uut (.clk(clk), .rstn(rstn), .insn_valid(insn_valid),
		.insn(insn), .insn_ready(insn_ready), .stack_top_entry(stack_top_entry),
		.stack_pop(stack_pop), .pc_load(pc_load), .pc_value(pc_value),
		.w_write(w_write), .w_data(w_data), .file_write(file_write),
		.file_addr(file_addr), .file_data(file_data), .carry_write(carry_write),
		.carry_value(carry_value), .timeout_flag_n(timeout_flag_n),
		.powerdown_flag_n(powerdown_flag_n), .watchdog_clear(watchdog_clear),
		.prescaler_clear(prescaler_clear), .watchdog_counter(watchdog_counter),
		.osc_stop(osc_stop), .halted(halted), .wake(wake));

	////////////////////////////////////////////////////////////////////////////
	function automatic rrs_row_s mk(rrs_op_e op, logic [7:0] lit, logic [6:0] a, logic d,
		logic [7:0] f, logic c, logic [4:0] p, logic cv, logic [7:0] res, logic rdy);
		mk = '{'{op, lit, a, d, f, c}, p, cv, res, rdy};
	endfunction : mk

	task report_and_stop();
		$display("checks %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : report_and_stop

	task chk(input string what, input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp)
		begin
			err_total++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// Bounded waits only, so a stuck handshake ends the run instead of hanging it.
	task wait_ready();
		int n;
		n = 0;
		while (insn_ready !== 1'b1)
		begin
			@(negedge clk);
			n++;
			if (n > 20)
			begin
				chk("insn_ready", insn_ready, 1'b1);
				report_and_stop();
			end
		end
	endtask : wait_ready

	////////////////////////////////////////////////////////////////////////////
	initial
	begin
		rows = '{mk(RRS_OP_ROT_LEFT, 8'h00, 7'h05, 1'b0, 8'hE6, 1'b0, 5'h05, 1'b1, 8'hCC, 1'b1),
			mk(RRS_OP_ROT_LEFT, 8'h00, 7'h7F, 1'b1, 8'hE6, 1'b1, 5'h03, 1'b1, 8'hCD, 1'b1),
			mk(RRS_OP_ROT_LEFT, 8'h00, 7'h00, 1'b1, 8'h00, 1'b1, 5'h03, 1'b0, 8'h01, 1'b1),
			mk(RRS_OP_ROT_LEFT, 8'h00, 7'h40, 1'b0, 8'h80, 1'b0, 5'h05, 1'b1, 8'h00, 1'b1),
			mk(RRS_OP_RET_LIT, 8'hFF, 7'h00, 1'b0, 8'h00, 1'b0, 5'h1C, 1'b0, 8'hFF, 1'b0),
			mk(RRS_OP_RETURN, 8'h00, 7'h00, 1'b0, 8'h00, 1'b0, 5'h18, 1'b0, 8'h00, 1'b0),
			mk(RRS_OP_RET_LIT, 8'h00, 7'h00, 1'b0, 8'h00, 1'b0, 5'h1C, 1'b0, 8'h00, 1'b0),
			mk(RRS_OP_NONE, 8'h00, 7'h00, 1'b0, 8'h00, 1'b0, 5'h00, 1'b0, 8'h00, 1'b1),
			mk(RRS_OP_ROT_LEFT, 8'h00, 7'h11, 1'b0, 8'h7F, 1'b0, 5'h05, 1'b0, 8'hFE, 1'b1)};
		repeat (5) @(negedge clk);
		chk("reset state", {insn_ready, timeout_flag_n, powerdown_flag_n, halted}, 4'h6);
		rstn = 1'b1;
		$display("test reset done");
		for (int i = 0; i < 9; i++)
		begin
			wait_ready();
			insn = rows[i].insn;
			insn_valid = 1'b1;
			stack_top_entry = 13'h1FFF - 13'(i);
			@(negedge clk);
			chk("pulses", {stack_pop, pc_load, w_write, file_write, carry_write}, rows[i].pulses);
			chk("insn_ready", insn_ready, rows[i].rdy);
			chk("flags", {timeout_flag_n, powerdown_flag_n}, 2'b11);
			if (rows[i].pulses[2])
				chk("w_data", w_data, rows[i].res);
			if (rows[i].pulses[1])
				chk("file", {file_addr, file_data}, {rows[i].insn.file_addr, rows[i].res});
			if (rows[i].pulses[0])
				chk("carry_value", carry_value, rows[i].cv);
			if (rows[i].pulses[4])
				chk("pc_value", pc_value, 13'h1FFF - 13'(i));
		end
		insn_valid = 1'b0;
		$display("test rows done");
		// Halt, then a rotate held during the halt must wait for the wake.
		wait_ready();
		insn = '{RRS_OP_HALT, 8'h00, 7'h00, 1'b0, 8'h00, 1'b0};
		insn_valid = 1'b1;
		@(negedge clk);
		chk("flags", {timeout_flag_n, powerdown_flag_n}, {RRS_TO_N_HALT, RRS_PD_N_HALT});
		chk("wdt", {watchdog_clear, prescaler_clear, watchdog_counter}, {2'b11, RRS_WDT_CLEAR});
		chk("halt", {osc_stop, halted, insn_ready}, 3'b110);
		insn = rows[0].insn;
		seen = 1'b0;
		repeat (6)
		begin
			@(negedge clk);
			seen = seen | carry_write | watchdog_clear | ~osc_stop;
		end
		chk("halt hold", seen, 1'b0);
		wake = 1'b1;
		wait_ready();
		wake = 1'b0;
		@(negedge clk);
		insn_valid = 1'b0;
		chk("after wake", {carry_write, carry_value, w_data}, {2'b11, 8'hCC});
		chk("flags", {timeout_flag_n, powerdown_flag_n}, 2'b10);
		$display("test halt done");
		rstn = 1'b0;
		@(negedge clk);
		chk("reset state", {insn_ready, timeout_flag_n, powerdown_flag_n, halted}, 4'h6);
		rstn = 1'b1;
		wait_ready();
		$display("test mid reset done");
		report_and_stop();
	end
endmodule : rrs_exec_test
